// File: tb/double_speed_clock_select_test.sv
// Purpose: Self-checking bench for the double-speed clock select block
// Assumes: Zero-wait APB slave, one-cycle clock-enable pulses
// Notes: Pulse spacing is counted on falling edges, clear of the update edge
`timescale 1ns/1ps
`default_nettype none
module double_speed_clock_select_test;
	import clk_speed_pkg::*;
	localparam logic [31:0] ZERO = 32'h0000_0000;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, h;
	logic        cpu_cycle_en, half_clk, double_speed_active;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [1:0]  uart_mode;
	logic [7:0]  periph_cycle_en;
	int          miscompares, compares;
	double_speed_clock_select uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .uart_mode(uart_mode),
		.cpu_cycle_en(cpu_cycle_en), .periph_cycle_en(periph_cycle_en),
		.half_clk(half_clk), .double_speed_active(double_speed_active));
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	task automatic tally_and_finish;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// Request held until pready is seen high at a rising edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Values read here are those sampled at this edge
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20)
			miscompares++;
		rd  = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	function automatic logic pulse(input int idx);
		return (idx == 8) ? cpu_cycle_en : periph_cycle_en[idx[2:0]];
	endfunction
	task automatic period(input int idx, output logic [31:0] p);
		int n;
		n = 0;
		p = ZERO;
		do begin
			@(negedge pclk);
			n++;
		end while (pulse(idx) !== 1'b1 && n < 40);
		do begin
			@(negedge pclk);
			p++;
		end while (pulse(idx) !== 1'b1 && p < 40);
		if (p >= 40)
			miscompares++;
	endtask
	function automatic logic [31:0] want(input int idx, input logic [7:0] c0,
		input logic c1, input logic [1:0] mode);
		logic slow;
		slow = (idx < 7) ? c0[idx[2:0]+3'd1] : c1;
		if (idx == 3 && mode[0]) slow = 1'b0;
		if (c0[0] !== 1'b1) return 32'h0000_000c;
		if (idx == 8) return 32'h0000_0006;
		return slow ? 32'h0000_000c : 32'h0000_0006;
	endfunction
	task automatic run_cfg(input logic [7:0] c0, input logic c1, input logic [1:0] mode);
		logic [31:0] p;
		uart_mode <= mode;
		apb(1'b1, CLOCK_SPEED_CONTROL_ADDR, {24'h00_0000, c0});
		apb(1'b1, SERIAL_PORT_SPEED_CONTROL_ADDR, {31'h0, c1});
		apb(1'b0, CLOCK_SPEED_CONTROL_ADDR, ZERO);
		chk(rd, {24'h00_0000, c0});
		apb(1'b0, SERIAL_PORT_SPEED_CONTROL_ADDR, ZERO);
		chk(rd & 32'h0000_0001, {31'h0, c1});
		chk({31'h0, double_speed_active}, {31'h0, c0[0]});
		// Two periods so a change in flight has finished
		for (int i = 0; i <= 8; i++) begin
			period(i, p);
			period(i, p);
			chk(p, want(i, c0, c1, mode));
		end
	endtask
	initial begin
		miscompares = 0;
		compares    = 0;
		presetn     = 1'b0;
		psel        = 1'b0;
		penable     = 1'b0;
		pwrite      = 1'b0;
		paddr       = 12'h000;
		pwdata      = ZERO;
		uart_mode   = 2'b00;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, CLOCK_SPEED_CONTROL_ADDR, ZERO);
		chk(rd, ZERO);
		chk({31'h0, err}, ZERO);
		apb(1'b0, SERIAL_PORT_SPEED_CONTROL_ADDR, ZERO);
		chk(rd & 32'h0000_0001, ZERO);
		apb(1'b1, 12'h100, 32'h0000_00ff);
		chk({31'h0, err}, 32'h0000_0001);
		@(negedge pclk);
		h = half_clk;
		@(negedge pclk);
		chk({31'h0, half_clk}, {31'h0, ~h});
		run_cfg(8'hfe, 1'b1, 2'b00);
		run_cfg(8'h01, 1'b0, 2'b00);
		run_cfg(8'hff, 1'b1, 2'b10);
		run_cfg(8'h55, 1'b0, 2'b01);
		run_cfg(8'h13, 1'b1, 2'b11);
		run_cfg(8'h11, 1'b0, 2'b10);
		presetn <= 1'b0;
		@(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, CLOCK_SPEED_CONTROL_ADDR, ZERO);
		chk(rd, ZERO);
		tally_and_finish();
	end
endmodule // double_speed_clock_select_test
`default_nettype wire

// File: verilog/clk_speed_pkg.sv
// Purpose: Constants for the double-speed clock select block
// Assumes: APB slave with 32-bit data, pclk as oscillator reference
// Notes: Register offsets are not word aligned, so they are indices
package clk_speed_pkg;
	localparam logic [7:0]  CLOCK_SPEED_CONTROL_IDX       = 8'h8f;
	localparam logic [7:0]  SERIAL_PORT_SPEED_CONTROL_IDX = 8'h9f;
	localparam logic [11:0] CLOCK_SPEED_CONTROL_ADDR      = {2'b00, CLOCK_SPEED_CONTROL_IDX, 2'b00};
	localparam logic [11:0] SERIAL_PORT_SPEED_CONTROL_ADDR = {2'b00, SERIAL_PORT_SPEED_CONTROL_IDX, 2'b00};
	localparam logic [7:0]  CLOCK_SPEED_CONTROL_RESET     = 8'h00;
	localparam logic [7:0]  SERIAL_PORT_SPEED_CONTROL_RESET = 8'h00;
	// Field positions in clock_speed_control; SPI_SPEED_BIT is in the second register
	localparam int CPU_DOUBLE_SPEED_BIT = 0;
	localparam int TIMER0_SPEED_BIT     = 1;
	localparam int TIMER1_SPEED_BIT     = 2;
	localparam int TIMER2_SPEED_BIT     = 3;
	localparam int UART_SPEED_BIT       = 4;
	localparam int COUNTER_ARRAY_BIT    = 5;
	localparam int WATCHDOG_SPEED_BIT   = 6;
	localparam int CAN_SPEED_BIT        = 7;
	localparam int SPI_SPEED_BIT        = 0;
	// Oscillator periods per cycle
	localparam logic [3:0] PERIODS_STANDARD = 4'd12;
	localparam logic [3:0] PERIODS_DOUBLE   = 4'd6;
	localparam logic [3:0] PERIOD_CNT_RESET = 4'h0;
	// Peripheral enable vector order: 0..6 from clock_speed_control bits 1..7, 7 is spi
	localparam int NUM_PERIPH = 8;
	localparam int UART_IDX   = 3;
endpackage

// File: verilog/double_speed_clock_select.sv
// Purpose: CPU and peripheral clock-rate selection, register mapped over APB
// Assumes: pclk is the oscillator input; enables are one-cycle strobes
// Notes: Peripheral clocks are clock enables, not gated clocks
// What this block does
// - Double-speed bit clear gives CPU and all peripherals 12 periods per cycle.
// - Double-speed bit set gives CPU 6 periods and honours peripheral bits.
// - Cleared peripheral bit gives that peripheral 6 periods per cycle.
// - Set peripheral bit keeps that peripheral at 12 periods per cycle.
// - Peripheral bits act only while the double-speed bit is set.
// - UART bit affects only UART modes 0 and 2.
// - Reserved bits 7 to 1 of second register need no defined read value.
// - Both control registers reset to all zeros, standard mode.
// - The halver runs in both modes; cycle length comes from the 12 or 6 period count.
// - Double-speed bit change takes effect only on a halved-clock rising edge.
`timescale 1ns/1ps
`default_nettype none
module double_speed_clock_select
	import clk_speed_pkg::*;
(
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// UART mode from the serial port
	input  wire logic [1:0]  uart_mode,
	// Clock enables, halved clock and double-speed status
	output logic             cpu_cycle_en,
	output logic [7:0]       periph_cycle_en,
	output logic             half_clk,
	output logic             double_speed_active
);
	import clk_speed_pkg::*;

	logic [7:0] clock_speed_control_reg;
	logic [7:0] serial_port_speed_control_reg;
	logic       x2_eff_reg;
	logic [3:0] cpu_cnt_reg;
	logic [3:0] cpu_cnt_next;
	logic [7:0] sel_reg;
	logic [7:0] sel_req;
	logic [3:0] pcnt_reg [NUM_PERIPH];
	logic       access;
	logic       hit0;
	logic       hit1;

	assign access = psel && penable;
	assign hit0 = paddr == CLOCK_SPEED_CONTROL_ADDR;
	assign hit1 = paddr == SERIAL_PORT_SPEED_CONTROL_ADDR;

	// Zero-wait slave: pready high in every access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clock_speed_control_reg       <= CLOCK_SPEED_CONTROL_RESET;
			serial_port_speed_control_reg <= SERIAL_PORT_SPEED_CONTROL_RESET;
		end else if (access && pwrite && hit0) begin
			clock_speed_control_reg <= pwdata[7:0];
		end else if (access && pwrite && hit1) begin
			// Reserved bits are not stored; software must keep them zero
			serial_port_speed_control_reg <= {7'h00, pwdata[SPI_SPEED_BIT]};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && !hit0 && !hit1;
			if (psel && !penable && hit0)
				prdata <= {24'h00_0000, clock_speed_control_reg};
			else if (psel && !penable && hit1)
				prdata <= {24'h00_0000, serial_port_speed_control_reg};
			else
				prdata <= 32'h0000_0000;
		end
	end

	// Halved oscillator reference, runs freely
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			half_clk <= 1'b0;
		else
			half_clk <= !half_clk;
	end

	// Mode bit is taken only where half_clk rises, avoiding a glitch
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			x2_eff_reg <= 1'b0;
		else if (!half_clk)
			x2_eff_reg <= clock_speed_control_reg[CPU_DOUBLE_SPEED_BIT];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			double_speed_active <= 1'b0;
		else
			double_speed_active <= x2_eff_reg;
	end

	// CPU machine cycle counter, limit chosen by effective mode
	always_comb begin
		if (cpu_cnt_reg >= (x2_eff_reg ? PERIODS_DOUBLE : PERIODS_STANDARD) - 4'd1)
			cpu_cnt_next = PERIOD_CNT_RESET;
		else
			cpu_cnt_next = cpu_cnt_reg + 4'd1;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cpu_cnt_reg  <= PERIOD_CNT_RESET;
			cpu_cycle_en <= 1'b0;
		end else begin
			cpu_cnt_reg  <= cpu_cnt_next;
			cpu_cycle_en <= cpu_cnt_next == PERIOD_CNT_RESET;
		end
	end

	// Requested standard-speed select per peripheral
	always_comb begin
		sel_req = {serial_port_speed_control_reg[SPI_SPEED_BIT], clock_speed_control_reg[7:1]};
		sel_req[UART_IDX] = clock_speed_control_reg[UART_SPEED_BIT] && !uart_mode[0];
		if (!x2_eff_reg)
			sel_req = 8'hff;
	end

	genvar g;
	for (g = 0; g < NUM_PERIPH; g++) begin : g_periph
		logic [3:0] limit;
		assign limit = sel_reg[g] ? PERIODS_STANDARD : PERIODS_DOUBLE;
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				pcnt_reg[g]        <= PERIOD_CNT_RESET;
				sel_reg[g]         <= 1'b1;
				periph_cycle_en[g] <= 1'b0;
			end else if (pcnt_reg[g] >= limit - 4'd1) begin
				// Select changes only at cycle end, so no short cycle
				pcnt_reg[g]        <= PERIOD_CNT_RESET;
				sel_reg[g]         <= sel_req[g];
				periph_cycle_en[g] <= 1'b1;
			end else begin
				pcnt_reg[g]        <= pcnt_reg[g] + 4'd1;
				periph_cycle_en[g] <= 1'b0;
			end
		end
	end

	// Pulse history is meaningless until one cycle has passed after reset
	logic cpu_seen_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			cpu_seen_reg <= 1'b0;
		else if (cpu_cycle_en)
			cpu_seen_reg <= 1'b1;
	end

	// CPU machine cycle checks
	chk_cpu_standard_rate: assert property (@(posedge pclk) disable iff (!presetn)
		cpu_cycle_en && !x2_eff_reg && $past(!x2_eff_reg, 12) && $past(cpu_seen_reg, 12)
		|-> $past(cpu_cycle_en, 12))
		else $error("cpu cycle not 12 periods");

	chk_cpu_double_rate: assert property (@(posedge pclk) disable iff (!presetn)
		cpu_cycle_en && x2_eff_reg && $past(x2_eff_reg, 6) |-> $past(cpu_cycle_en, 6))
		else $error("cpu cycle not 6 periods");

	chk_cpu_pulse_single: assert property (@(posedge pclk) disable iff (!presetn)
		cpu_cycle_en |=> !cpu_cycle_en)
		else $error("cpu cycle enable longer than one cycle");

	chk_cpu_cnt_range: assert property (@(posedge pclk) disable iff (!presetn)
		cpu_cnt_reg < PERIODS_STANDARD)
		else $error("cpu cycle counter out of range");

	chk_active_follow: assert property (@(posedge pclk) disable iff (!presetn)
		double_speed_active == $past(x2_eff_reg))
		else $error("double speed flag does not follow mode");

	// Peripheral enable checks
	chk_periph_fast: assert property (@(posedge pclk) disable iff (!presetn)
		periph_cycle_en[0] && !sel_reg[0] |=> !periph_cycle_en[0] [*5] ##1 periph_cycle_en[0])
		else $error("fast peripheral cycle not 6");

	chk_periph_slow: assert property (@(posedge pclk) disable iff (!presetn)
		periph_cycle_en[7] && sel_reg[7] |=> !periph_cycle_en[7] [*8]
		##1 !periph_cycle_en[7] [*3] ##1 periph_cycle_en[7])
		else $error("slow peripheral cycle not 12");

	chk_std_forces_slow: assert property (@(posedge pclk) disable iff (!presetn)
		!x2_eff_reg |-> sel_req == 8'hff)
		else $error("peripheral bit acted in standard mode");

	chk_uart_mode_gate: assert property (@(posedge pclk) disable iff (!presetn)
		uart_mode[0] && x2_eff_reg |-> !sel_req[UART_IDX])
		else $error("uart speed bit acted in mode 1 or 3");

	chk_uart_bit_used: assert property (@(posedge pclk) disable iff (!presetn)
		!uart_mode[0] && x2_eff_reg
		|-> sel_req[UART_IDX] == clock_speed_control_reg[UART_SPEED_BIT])
		else $error("uart speed bit ignored in mode 0 or 2");

	for (g = 0; g < NUM_PERIPH; g++) begin : g_periph_chk
		chk_fast_spacing: assert property (@(posedge pclk) disable iff (!presetn)
			periph_cycle_en[g] && !sel_reg[g]
			|=> !periph_cycle_en[g] [*5] ##1 periph_cycle_en[g])
			else $error("peripheral fast cycle not 6 periods");

		chk_slow_spacing: assert property (@(posedge pclk) disable iff (!presetn)
			periph_cycle_en[g] && sel_reg[g] |=> !periph_cycle_en[g] [*8]
			##1 !periph_cycle_en[g] [*3] ##1 periph_cycle_en[g])
			else $error("peripheral slow cycle not 12 periods");

		chk_sel_at_end: assert property (@(posedge pclk) disable iff (!presetn)
			$changed(sel_reg[g]) |-> periph_cycle_en[g])
			else $error("peripheral select changed mid cycle");

		chk_std_slow: assert property (@(posedge pclk) disable iff (!presetn)
			!x2_eff_reg && $past(!x2_eff_reg, 12) |-> sel_reg[g])
			else $error("peripheral not slow in standard mode");

		chk_pcnt_range: assert property (@(posedge pclk) disable iff (!presetn)
			pcnt_reg[g] < PERIODS_STANDARD)
			else $error("peripheral counter out of range");
	end

	// Mode switch, halved clock, select boundary and reserved bit checks
	chk_mode_on_half: assert property (@(posedge pclk) disable iff (!presetn)
		$changed(x2_eff_reg) |-> $past(!half_clk))
		else $error("mode changed off halved edge");

	chk_half_toggle: assert property (@(posedge pclk) disable iff (!presetn)
		half_clk |=> !half_clk ##1 half_clk)
		else $error("halved clock not toggling");

	chk_sel_boundary: assert property (@(posedge pclk) disable iff (!presetn)
		$changed(sel_reg[1]) |-> periph_cycle_en[1])
		else $error("peripheral select changed mid cycle");

	chk_spi_reserved: assert property (@(posedge pclk) disable iff (!presetn)
		serial_port_speed_control_reg[7:1] == 7'h00)
		else $error("reserved bits stored");

	// Register bus checks
	chk_ready_after_setup: assert property (@(posedge pclk) disable iff (!presetn)
		pready |-> $past(psel && !penable))
		else $error("ready without a setup cycle");

	chk_ready_one_cycle: assert property (@(posedge pclk) disable iff (!presetn)
		pready |=> !pready)
		else $error("ready held longer than one cycle");

	chk_err_with_ready: assert property (@(posedge pclk) disable iff (!presetn)
		pslverr |-> pready)
		else $error("error response without ready");

	chk_err_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
		pready && $past(!hit0 && !hit1) |-> pslverr)
		else $error("unmapped access not flagged");

	chk_write_lands0: assert property (@(posedge pclk) disable iff (!presetn)
		access && pwrite && hit0 |=> clock_speed_control_reg == $past(pwdata[7:0]))
		else $error("first control register write lost");

	chk_write_lands1: assert property (@(posedge pclk) disable iff (!presetn)
		access && pwrite && hit1
		|=> serial_port_speed_control_reg == {7'h00, $past(pwdata[SPI_SPEED_BIT])})
		else $error("second control register write lost");

	chk_write_ignored: assert property (@(posedge pclk) disable iff (!presetn)
		access && pwrite && !hit0 && !hit1
		|=> $stable(clock_speed_control_reg) && $stable(serial_port_speed_control_reg))
		else $error("unmapped write changed a register");

	chk_read_keeps: assert property (@(posedge pclk) disable iff (!presetn)
		access && !pwrite
		|=> $stable(clock_speed_control_reg) && $stable(serial_port_speed_control_reg))
		else $error("read changed a register");

	chk_read_data: assert property (@(posedge pclk) disable iff (!presetn)
		pready && $past(hit0) |-> prdata == {24'h00_0000, $past(clock_speed_control_reg)})
		else $error("read data does not match register");

	chk_unmapped_zero: assert property (@(posedge pclk) disable iff (!presetn)
		pslverr |-> prdata == 32'h0000_0000)
		else $error("unmapped read returned data");

	chk_idle_zero: assert property (@(posedge pclk) disable iff (!presetn)
		!pready |-> prdata == 32'h0000_0000)
		else $error("read data outside access cycle");
endmodule // double_speed_clock_select
`default_nettype wire
